// ### bench/iers_core_assertions.sv
// Concurrent checks on the bus handshake and core outputs of the execution slice.
`timescale 1ns/100ps
module iers_core_assertions import iers_pkg::*; (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Bus and core state.
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [BUS_W-1:0] avs_writedata,
    input wire logic [BUS_W-1:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic halted,
    input wire logic [PC_W-1:0] prog_counter
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    sequence s_cmd_done(int op);
        avs_write && !avs_waitrequest && avs_address == OFF_CMD && avs_writedata[2:0] == op;
    endsequence
    AST_WAIT_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("answer longer than one cycle");
    AST_ANSWER_BOUND: assert property ((avs_read || avs_write) && avs_waitrequest
        |-> ##[1:4] !avs_waitrequest) else $error("bus answer too late");
    AST_NO_SPURIOUS: assert property ($fell(avs_waitrequest) |-> $past(avs_read || avs_write))
        else $error("answer without request");
    AST_RD_LOAD: assert property ($changed(avs_readdata) |-> $past(avs_read))
        else $error("read data moved without read");
    AST_CMD_READ_ZERO: assert property (avs_read && !avs_waitrequest && avs_address == OFF_CMD
        |-> avs_readdata == '0) else $error("command word read not zero");
    AST_HALT_STICKY: assert property (halted |=> halted)
        else $error("halted state left");
    AST_HALT_ENTRY: assert property (s_cmd_done(3) |=> ##1 halted)
        else $error("halt command did not halt");
    AST_HALT_CAUSE: assert property ($rose(halted)
        |-> $past(avs_write && !avs_waitrequest && avs_address == OFF_CMD, 2))
        else $error("halted without command");
    AST_HALT_PC_STEP: assert property ($rose(halted)
        |-> prog_counter == $past(prog_counter) + 13'h1) else $error("halt pc step wrong");
    AST_PC_CAUSE: assert property ($changed(prog_counter)
        |-> $past(avs_write) || $past(avs_write, 2)) else $error("pc moved without write");
endmodule : iers_core_assertions

bind iers_core iers_core_assertions u_chk (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .halted(halted), .prog_counter(prog_counter));

// ### bench/tb_top.sv
// Self-checking bench for the execution slice, driven over its register bus.
`timescale 1ns/100ps
module tb_top import iers_pkg::*;;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [ADDR_W-1:0] avs_address = '0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [BUS_W-1:0] avs_writedata = '0;
    logic [BUS_W-1:0] avs_readdata;
    logic avs_waitrequest;
    logic halted;
    logic [PC_W-1:0] prog_counter;
    int n_errors = 0;
    int n_tests = 0;
    int cycles = 0;
    int lat;
    always #5 ref_clk = ~ref_clk;
    iers_core uut (.ref_clk(ref_clk), .sys_rst(sys_rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .halted(halted),
        .prog_counter(prog_counter));
    task automatic check(input string name, input logic [BUS_W-1:0] seen,
        input logic [BUS_W-1:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    // The request is held until waitrequest is sampled low, then dropped.
    task automatic bus(input logic wr_en, input logic [ADDR_W-1:0] addr,
        input logic [BUS_W-1:0] wdata, output logic [BUS_W-1:0] rdata);
        @(posedge ref_clk);
        avs_address <= addr;
        avs_write <= wr_en;
        avs_read <= !wr_en;
        avs_writedata <= wdata;
        lat = 0;
        do begin
            @(posedge ref_clk);
            lat++;
        end while (avs_waitrequest !== 1'b0);
        rdata = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus
    task automatic wr(input logic [ADDR_W-1:0] addr, input logic [BUS_W-1:0] wdata);
        logic [BUS_W-1:0] d;
        bus(1'b1, addr, wdata, d);
    endtask : wr
    task automatic rd(input string name, input logic [ADDR_W-1:0] addr,
        input logic [BUS_W-1:0] exp);
        logic [BUS_W-1:0] d;
        bus(1'b0, addr, '0, d);
        check(name, d, exp);
    endtask : rd
    function automatic logic [BUS_W-1:0] cmd(int op, int f, int dst, int k);
        return {8'h00, 8'(k), 5'h00, 1'(dst), 7'(f), 3'(op)};
    endfunction : cmd
    function automatic logic [ADDR_W-1:0] fa(int n);
        return 10'(32'h200 + 4 * n);
    endfunction : fa
    task automatic t_reset;
        rd("status", OFF_STATUS, 32'h0000_0018);
        rd("acc", OFF_ACC, 32'h0000_0000);
        wr(10'h100, 32'hffff_ffff);
        rd("unmapped", 10'h100, 32'h0000_0000);
        rd("cmd", OFF_CMD, 32'h0000_0000);
        $display("test reset done");
    endtask : t_reset
    task automatic t_rotate;
        logic [7:0] fin[4] = '{8'h81, 8'h40, 8'h01, 8'h7e};
        logic [7:0] r;
        logic ci;
        logic co;
        for (int i = 0; i < 4; i++) begin
            ci = i[0];
            r = (i < 2) ? {fin[i][6:0], ci} : {ci, fin[i][7:1]};
            co = (i < 2) ? fin[i][7] : fin[i][0];
            wr(fa(i * 40 + 7), {24'h0, fin[i]});
            wr(OFF_ACC, 32'h55);
            wr(OFF_STATUS, {27'h0, 4'hd, ci});
            wr(OFF_CMD, cmd((i < 2) ? 1 : 2, i * 40 + 7, i[0], 0));
            rd("rot acc", OFF_ACC, {24'h0, i[0] ? 8'h55 : r});
            rd("rot file", fa(i * 40 + 7), {24'h0, i[0] ? r : fin[i]});
            rd("rot status", OFF_STATUS, {27'h0, 4'hd, co});
        end
        rd("pc", OFF_PC, 32'h4);
        $display("test rotate done");
    endtask : t_rotate
    task automatic t_sub;
        logic [7:0] av[5] = '{8'h05, 8'h02, 8'h10, 8'h23, 8'h00};
        logic [7:0] wv[5] = '{8'h05, 8'h03, 8'h01, 8'h01, 8'h80};
        logic [7:0] r;
        logic [2:0] fl;
        for (int i = 0; i < 5; i++) begin
            r = av[i] - wv[i];
            fl = {r == 8'h0, av[i][3:0] >= wv[i][3:0], av[i] >= wv[i]};
            wr(fa(127), {24'h0, av[i]});
            wr(OFF_ACC, {24'h0, wv[i]});
            wr(OFF_STATUS, {27'h3, i[0] ? 3'h7 : 3'h0});
            wr(OFF_CMD, cmd((i < 3) ? 4 : 5, 127, i == 3, av[i]));
            rd("sub acc", OFF_ACC, {24'h0, (i == 3) ? wv[i] : r});
            rd("sub file", fa(127), {24'h0, (i == 3) ? r : av[i]});
            rd("sub status", OFF_STATUS, {27'h3, fl});
        end
        $display("test subtract done");
    endtask : t_sub
    task automatic t_return;
        logic [BUS_W-1:0] c0;
        bus(1'b0, OFF_CYCLES, '0, c0);
        wr(OFF_PC, 32'h10);
        wr(OFF_STACK, 32'h0123);
        wr(OFF_STACK, 32'h1abc);
        wr(OFF_STATUS, 32'h15);
        wr(OFF_CMD, cmd(0, 0, 0, 0));
        rd("ret pc", OFF_PC, 32'h1abc);
        check("ret wait", 32'(lat), 32'h3);
        wr(OFF_CMD, cmd(0, 0, 0, 0));
        rd("ret pc2", OFF_PC, 32'h0123);
        check("ret pin", {19'h0, prog_counter}, 32'h0123);
        rd("ret level", OFF_STACK, 32'h0);
        wr(OFF_CMD, cmd(7, 0, 0, 0));
        rd("ign pc", OFF_PC, 32'h0123);
        rd("ret status", OFF_STATUS, 32'h15);
        rd("ret cycles", OFF_CYCLES, {16'h0, 16'(c0 + 4)});
        $display("test return done");
    endtask : t_return
    task automatic t_halt;
        logic [BUS_W-1:0] d;
        repeat (300) @(posedge ref_clk);
        wr(OFF_ACC, 32'h33);
        wr(OFF_STATUS, 32'h0f);
        wr(OFF_CMD, cmd(3, 0, 0, 0));
        bus(1'b0, OFF_WDOG, '0, d);
        check("wdog", {24'h0, d[7:0]}, 32'h0);
        check("presc", {31'h0, d[15:8] < 8'h10}, 32'h1);
        rd("halt status", OFF_STATUS, 32'h217);
        check("halted", {31'h0, halted}, 32'h1);
        wr(OFF_CMD, cmd(4, 0, 0, 8'h40));
        rd("halt acc", OFF_ACC, 32'h33);
        @(posedge ref_clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        sys_rst <= 1'b0;
        check("unhalted", {31'h0, halted}, 32'h0);
        rd("rst status", OFF_STATUS, 32'h18);
        $display("test halt done");
    endtask : t_halt
    task automatic test_done;
        $display("checks %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : test_done
    initial begin
        repeat (6) @(posedge ref_clk);
        sys_rst <= 1'b0;
        t_reset;
        t_rotate;
        t_sub;
        t_return;
        t_halt;
        test_done;
    end
    // The whole run needs well under a thousand cycles.
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_errors = n_errors + 1;
            test_done;
        end
    end
endmodule : tb_top

// ### src/iers_alu.sv
// Rotate and subtract arithmetic with flag results.
`timescale 1ns/100ps
module iers_alu import iers_pkg::*; (
    // Operands and results.
    iers_alu_if.alu a
);
    always_comb begin
        logic [DATA_W-1:0] minuend;
        logic [DATA_W:0] diff;
        logic [4:0] half;
        minuend = (a.op == literal_minus_acc_op) ? a.lit : a.f_val;
        // Subtraction as addition of the complement plus one.
        diff = {1'b0, minuend} + {1'b0, ~a.acc} + 9'h001;
        half = {1'b0, minuend[3:0]} + {1'b0, ~a.acc[3:0]} + 5'h01;
        a.result = 8'h00;
        a.c_out = a.c_in;
        a.hb_out = 1'b0;
        a.z_out = 1'b0;
        a.upd_c = 1'b0;
        a.upd_dcz = 1'b0;
        unique case (a.op)
            rotate_left_op: begin
                a.result = {a.f_val[DATA_W-2:0], a.c_in};
                a.c_out = a.f_val[DATA_W-1];
                a.upd_c = 1'b1;
            end
            rotate_right_op: begin
                a.result = {a.c_in, a.f_val[DATA_W-1:1]};
                a.c_out = a.f_val[0];
                a.upd_c = 1'b1;
            end
            literal_minus_acc_op, file_minus_acc_op: begin
                a.result = diff[DATA_W-1:0];
                a.c_out = diff[DATA_W];
                a.hb_out = half[4];
                a.z_out = (diff[DATA_W-1:0] == 8'h00);
                a.upd_c = 1'b1;
                a.upd_dcz = 1'b1;
            end
            default: begin
            end
        endcase
    end
endmodule : iers_alu

// ### src/iers_core.sv
// Execution slice for exit, rotate, halt and subtract, with an Avalon-MM slave.
//
// Overview of operation
// - Subroutine exit pops the stack into the program counter over two cycles.
// - Rotate left through carry: carry into bit 0, bit 7 into carry.
// - Rotate right through carry: carry into bit 7, bit 0 into carry.
// - Destination bit 0 selects accumulator, 1 the file register; addresses 0 to 127.
// - Halt clears the powerdown flag and sets the expiry flag.
// - Halt zeroes the watchdog counter and its prescaler.
// - After halt the core sits halted, taking no further commands, until reset.
// - Literal minus accumulator goes to the accumulator, updating carry, half-byte and zero.
// - File minus accumulator goes to the chosen destination, updating carry, half-byte, zero.
`timescale 1ns/100ps
module iers_core import iers_pkg::*; (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Avalon-MM slave.
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [BUS_W-1:0] avs_writedata,
    output logic [BUS_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    // Core state seen by the rest of the chip.
    output logic halted,
    output logic [PC_W-1:0] prog_counter
);
    typedef struct packed {
        iers_state_t state;
        logic [CMD_OP_W-1:0] op;
        logic [FADDR_W-1:0] faddr;
        logic dest;
        logic [DATA_W-1:0] lit;
        logic [DATA_W-1:0] acc;
        logic [ST_W-1:0] status;
        logic [PC_W-1:0] pc;
        logic halted;
        logic [WDOG_W-1:0] wdog;
        logic [PRESC_W-1:0] presc;
        logic [CYC_W-1:0] cycles;
        logic [FILE_WORDS-1:0][DATA_W-1:0] file;
        logic waitreq;
        logic [BUS_W-1:0] rdata;
    } iers_core_t;

    iers_core_t cur_r;
    iers_core_t cur_nxt;

    iers_alu_if alu_c ();
    iers_stack_if stk_c ();

    iers_alu u_alu (
        .a(alu_c.alu)
    );

    iers_stack #(
        .DEPTH(STACK_DEPTH)
    ) u_stack (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .s(stk_c.stk)
    );

    always_comb begin
        logic req;
        logic file_sel;
        logic [FADDR_W-1:0] fidx;
        logic [BUS_W-1:0] rd;
        req = avs_read | avs_write;
        file_sel = avs_address[FILE_SEL_BIT];
        fidx = avs_address[WORD_LSB +: FADDR_W];
        rd = '0;
        cur_nxt = cur_r;
        stk_c.push = 1'b0;
        stk_c.pop = 1'b0;
        stk_c.push_val = avs_writedata[PC_W-1:0];
        // Operands for the arithmetic come straight from the registers and the latched command.
        alu_c.op = iers_op_t'(cur_r.op);
        alu_c.f_val = cur_r.file[cur_r.faddr];
        alu_c.acc = cur_r.acc;
        alu_c.lit = cur_r.lit;
        alu_c.c_in = cur_r.status[ST_C];

        // The watchdog keeps its own time base, so it runs even while halted.
        cur_nxt.presc = cur_r.presc + PRESC_W'(1);
        if (cur_r.presc == {PRESC_W{1'b1}}) begin
            cur_nxt.wdog = cur_r.wdog + WDOG_W'(1);
        end

        // Read mux.
        if (file_sel) begin
            rd[DATA_W-1:0] = cur_r.file[fidx];
        end else begin
            unique case (avs_address)
                OFF_ACC: rd[DATA_W-1:0] = cur_r.acc;
                OFF_STATUS: begin
                    rd[ST_W-1:0] = cur_r.status;
                    rd[ST_BUSY] = (cur_r.state != st_idle);
                    rd[ST_HALT] = cur_r.halted;
                end
                OFF_PC: rd[PC_W-1:0] = cur_r.pc;
                OFF_STACK: rd[STK_PTR_W-1:0] = stk_c.level;
                OFF_WDOG: rd[WDOG_W+PRESC_W-1:0] = {cur_r.presc, cur_r.wdog};
                OFF_CYCLES: rd[CYC_W-1:0] = cur_r.cycles;
                default: rd = '0;
            endcase
        end

        // Bus handshake: a request is accepted only while no instruction runs,
        // which stalls the master instead of losing a command. The write
        // lands on the edge at which the master sees waitrequest low.
        cur_nxt.waitreq = 1'b1;
        if (req && cur_r.waitreq && cur_r.state == st_idle) begin
            cur_nxt.waitreq = 1'b0;
            // Writes leave the last read data standing.
            if (avs_read) begin
                cur_nxt.rdata = rd;
            end
        end else if (req && !cur_r.waitreq && avs_write) begin
            if (file_sel) begin
                cur_nxt.file[fidx] = avs_writedata[DATA_W-1:0];
            end else begin
                unique case (avs_address)
                    OFF_CMD: begin
                        // A halted core takes no further commands.
                        if (!cur_r.halted) begin
                            cur_nxt.op = avs_writedata[CMD_OP_LSB +: CMD_OP_W];
                            cur_nxt.faddr = avs_writedata[CMD_F_LSB +: FADDR_W];
                            cur_nxt.dest = avs_writedata[CMD_DEST_BIT];
                            cur_nxt.lit = avs_writedata[CMD_LIT_LSB +: DATA_W];
                            cur_nxt.state = st_exec;
                        end
                    end
                    OFF_ACC: cur_nxt.acc = avs_writedata[DATA_W-1:0];
                    OFF_STATUS: cur_nxt.status = avs_writedata[ST_W-1:0];
                    OFF_PC: cur_nxt.pc = avs_writedata[PC_W-1:0];
                    OFF_STACK: stk_c.push = 1'b1;
                    default: begin
                    end
                endcase
            end
        end

        // Instruction execution.
        unique case (cur_r.state)
            st_idle: begin
            end
            st_exec: begin
                cur_nxt.cycles = cur_r.cycles + CYC_W'(1);
                cur_nxt.state = st_idle;
                unique case (cur_r.op)
                    return_op: begin
                        stk_c.pop = 1'b1;
                        cur_nxt.pc = stk_c.head;
                        cur_nxt.state = st_ret2;
                    end
                    halt_op: begin
                        cur_nxt.status[ST_PWRDN] = 1'b0;
                        cur_nxt.status[ST_EXPIRY] = 1'b1;
                        cur_nxt.wdog = '0;
                        cur_nxt.presc = '0;
                        cur_nxt.halted = 1'b1;
                        cur_nxt.pc = cur_r.pc + PC_W'(1);
                    end
                    rotate_left_op, rotate_right_op,
                    literal_minus_acc_op, file_minus_acc_op: begin
                        if (cur_r.op == literal_minus_acc_op || !cur_r.dest) begin
                            cur_nxt.acc = alu_c.result;
                        end else begin
                            cur_nxt.file[cur_r.faddr] = alu_c.result;
                        end
                        if (alu_c.upd_c) begin
                            cur_nxt.status[ST_C] = alu_c.c_out;
                        end
                        if (alu_c.upd_dcz) begin
                            cur_nxt.status[ST_HB] = alu_c.hb_out;
                            cur_nxt.status[ST_Z] = alu_c.z_out;
                        end
                        cur_nxt.pc = cur_r.pc + PC_W'(1);
                    end
                    default: begin
                        // Undefined codes are dropped without side effects.
                        cur_nxt.cycles = cur_r.cycles;
                    end
                endcase
            end
            st_ret2: begin
                cur_nxt.cycles = cur_r.cycles + CYC_W'(1);
                cur_nxt.state = st_idle;
            end
            default: begin
                cur_nxt.state = st_idle;
            end
        endcase
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cur_r <= '0;
            cur_r.status <= STATUS_RST;
            cur_r.acc <= ACC_RST;
            cur_r.pc <= PC_RST;
            cur_r.waitreq <= 1'b1;
        end else begin
            cur_r <= cur_nxt;
        end
    end

    assign avs_readdata = cur_r.rdata;
    assign avs_waitrequest = cur_r.waitreq;
    assign halted = cur_r.halted;
    assign prog_counter = cur_r.pc;
endmodule : iers_core

// ### src/iers_if.sv
// Carriers between the core and its arithmetic and stack modules.
`timescale 1ns/100ps
interface iers_alu_if import iers_pkg::*; ();
    iers_op_t op;
    logic [DATA_W-1:0] f_val;
    logic [DATA_W-1:0] acc;
    logic [DATA_W-1:0] lit;
    logic c_in;
    logic [DATA_W-1:0] result;
    logic c_out;
    logic hb_out;
    logic z_out;
    logic upd_c;
    logic upd_dcz;
    modport core (output op, f_val, acc, lit, c_in,
        input result, c_out, hb_out, z_out, upd_c, upd_dcz);
    modport alu (input op, f_val, acc, lit, c_in,
        output result, c_out, hb_out, z_out, upd_c, upd_dcz);
endinterface : iers_alu_if

interface iers_stack_if import iers_pkg::*; ();
    logic push;
    logic pop;
    logic [PC_W-1:0] push_val;
    logic [PC_W-1:0] head;
    logic [STK_PTR_W-1:0] level;
    modport core (output push, pop, push_val, input head, level);
    modport stk (input push, pop, push_val, output head, level);
endinterface : iers_stack_if

// ### src/iers_pkg.sv
// Shared constants, register map and types of the execution slice.
package iers_pkg;
    localparam int DATA_W = 8;
    localparam int PC_W = 13;
    localparam int FADDR_W = 7;
    localparam int FILE_WORDS = 128;
    localparam int STACK_DEPTH = 8;
    localparam int STK_PTR_W = 3;
    localparam int ADDR_W = 10;
    localparam int BUS_W = 32;
    localparam int WDOG_W = 8;
    localparam int PRESC_W = 8;
    localparam int CYC_W = 16;

    // Byte offsets on the register bus.
    localparam logic [ADDR_W-1:0] OFF_CMD = 10'h000;
    localparam logic [ADDR_W-1:0] OFF_ACC = 10'h004;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 10'h008;
    localparam logic [ADDR_W-1:0] OFF_PC = 10'h00c;
    localparam logic [ADDR_W-1:0] OFF_STACK = 10'h010;
    localparam logic [ADDR_W-1:0] OFF_WDOG = 10'h014;
    localparam logic [ADDR_W-1:0] OFF_CYCLES = 10'h018;
    localparam int FILE_SEL_BIT = 9;
    localparam int WORD_LSB = 2;

    // Command word fields.
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_OP_W = 3;
    localparam int CMD_F_LSB = 3;
    localparam int CMD_DEST_BIT = 10;
    localparam int CMD_LIT_LSB = 16;

    // Status word bits.
    localparam int ST_C = 0;
    localparam int ST_HB = 1;
    localparam int ST_Z = 2;
    localparam int ST_PWRDN = 3;
    localparam int ST_EXPIRY = 4;
    localparam int ST_W = 5;
    localparam int ST_BUSY = 8;
    localparam int ST_HALT = 9;

    localparam logic [ST_W-1:0] STATUS_RST = 5'h18;
    localparam logic [DATA_W-1:0] ACC_RST = 8'h00;
    localparam logic [PC_W-1:0] PC_RST = 13'h0000;

    typedef enum logic [CMD_OP_W-1:0] {
        return_op,
        rotate_left_op,
        rotate_right_op,
        halt_op,
        literal_minus_acc_op,
        file_minus_acc_op
    } iers_op_t;

    typedef enum logic [1:0] {
        st_idle,
        st_exec,
        st_ret2
    } iers_state_t;
endpackage : iers_pkg

// ### src/iers_stack.sv
// Circular return stack; the head is the most recent entry.
`timescale 1ns/100ps
module iers_stack import iers_pkg::*; #(
    parameter int DEPTH = STACK_DEPTH
) (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Core side.
    iers_stack_if.stk s
);
    localparam int PTR_W = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][PC_W-1:0] ent;
        logic [PTR_W-1:0] ptr;
    } iers_stk_t;

    iers_stk_t stk_r;
    iers_stk_t stk_nxt;

    // Overflow and underflow wrap silently, as the pointer is circular.
    always_comb begin
        stk_nxt = stk_r;
        if (s.push) begin
            stk_nxt.ent[stk_r.ptr] = s.push_val;
            stk_nxt.ptr = stk_r.ptr + PTR_W'(1);
        end else if (s.pop) begin
            stk_nxt.ptr = stk_r.ptr - PTR_W'(1);
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            stk_r <= '0;
        end else begin
            stk_r <= stk_nxt;
        end
    end

    assign s.head = stk_r.ent[stk_r.ptr - PTR_W'(1)];
    assign s.level = STK_PTR_W'(stk_r.ptr);
endmodule : iers_stack
